// file: rtl/fbbu_defs.svh
// Constants for the flag, branch and bit-operation execution unit.
// Assumes a 100 MHz core clock and a decoder that presents one operation per cycle.
// What this block does
// - Branch on carry clear, same-or-higher alias
// - Branch on carry set, no flag change
// - Branch on negative set or clear
// - Branch when N xor V is zero
// - Branch when N xor V is one
// - Branch on half-carry set or clear
// - Branch on transfer bit, flags untouched
// - Branch on overflow set or clear
// - Branch on interrupt enable set or clear
// - I/O bit set or clear, two cycles
// - Left shift, zero into bit 0
// - Right shift, zero into bit 7
// - Rotate left through carry
// - Rotate right through carry
// - Arithmetic right shift keeps bit 7
// - Set or clear single status flags
// - Copy register bit into transfer bit
// - Copy transfer bit into register bit
`ifndef FBBU_DEFS_SVH
`define FBBU_DEFS_SVH
`define FBBU_FLAG_C 3'h0
`define FBBU_FLAG_Z 3'h1
`define FBBU_FLAG_N 3'h2
`define FBBU_FLAG_V 3'h3
`define FBBU_FLAG_S 3'h4
`define FBBU_FLAG_H 3'h5
`define FBBU_FLAG_T 3'h6
`define FBBU_FLAG_I 3'h7
`define FBBU_STATUS_RESET 8'h00
`define FBBU_PC_RESET 16'h0000
`define FBBU_BRANCH_TAKEN_CYCLES 2
`define FBBU_IO_BIT_CYCLES 2
`endif

// file: rtl/fbbu_pkg.sv
// Types shared by the execution unit and its helpers.
// Assumes the decoder encodes operations with fbbu_op_t.
`default_nettype none
package fbbu_pkg;
  typedef enum logic [4:0]
  {
    OP_NONE,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_ZERO,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT,
    OP_FLAG_SET_BY_INDEX,
    OP_FLAG_CLEAR_BY_INDEX,
    OP_BIT_TO_XFERBIT,
    OP_XFERBIT_TO_BIT
  } fbbu_op_t;

  typedef enum logic [3:0]
  {
    SH_LSL,
    SH_LSR,
    SH_ROL,
    SH_ROR,
    SH_ASR
  } fbbu_shift_t;

  typedef enum
  {
    ST_IDLE,
    ST_SECOND
  } fbbu_state_t;
endpackage : fbbu_pkg
`default_nettype wire

// file: rtl/fbbu_shifter.sv
// Combinational shift and rotate datapath with flag results.
// Assumes the caller merges flags into the status register.
`default_nettype none
`include "fbbu_defs.svh"
module fbbu_shifter
(
  input  wire logic                 carryIn,
  input  wire logic [7:0]           operand,
  input  wire fbbu_pkg::fbbu_shift_t kind,
  output logic      [7:0]           result,
  output logic                      carryOut,
  output logic                      zeroOut,
  output logic                      negOut,
  output logic                      ovfOut,
  output logic                      signOut
);
  always_comb
  begin
    result   = operand;
    carryOut = carryIn;
    case (kind)
      fbbu_pkg::SH_LSL:
      begin
        result   = {operand[6:0], 1'b0};
        carryOut = operand[7];
      end
      fbbu_pkg::SH_LSR:
      begin
        result   = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      fbbu_pkg::SH_ROL:
      begin
        result   = {operand[6:0], carryIn};
        carryOut = operand[7];
      end
      fbbu_pkg::SH_ROR:
      begin
        result   = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      fbbu_pkg::SH_ASR:
      begin
        result   = {operand[7], operand[7:1]};
        carryOut = operand[0];
      end
      default:
      begin
        result   = operand;
        carryOut = carryIn;
      end
    endcase
    zeroOut = (result == 8'h00);
    negOut  = result[7];
    // Overflow after a shift is N xor C, as for every ALU result on this core
    ovfOut  = result[7] ^ carryOut;
    signOut = negOut ^ ovfOut;
  end
endmodule : fbbu_shifter
`default_nettype wire

// file: rtl/fbbu_branch_target.sv
// Relative branch target: next address plus signed offset.
// Assumes the program counter holds the address of the branch word.
`default_nettype none
module fbbu_branch_target
#(
  parameter int PC_WIDTH  = 16,
  parameter int OFS_WIDTH = 7
)
(
  input  wire logic [PC_WIDTH-1:0]  pcNow,
  input  wire logic [OFS_WIDTH-1:0] offset,
  output logic      [PC_WIDTH-1:0]  target
);
  logic [PC_WIDTH-1:0] offsetExt;
  // Sign extension lets a branch reach backwards as well as forwards
  assign offsetExt = {{(PC_WIDTH-OFS_WIDTH){offset[OFS_WIDTH-1]}}, offset};
  assign target    = pcNow + offsetExt + {{(PC_WIDTH-1){1'b0}}, 1'b1};
endmodule : fbbu_branch_target
`default_nettype wire

// file: rtl/fbbu_exec_unit.sv
// Execution unit for flag branches, I/O bit ops, shifts and flag transfers.
// Assumes the decoder holds opValid until opDone and supplies register and I/O reads.
`default_nettype none
`include "fbbu_defs.svh"
module fbbu_exec_unit
#(
  parameter int PC_WIDTH  = 16,
  parameter int OFS_WIDTH = 7,
  parameter int IO_AW     = 5
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  opValid,
  input  wire fbbu_pkg::fbbu_op_t    opCode,
  input  wire logic [2:0]            opBitSel,
  input  wire logic [OFS_WIDTH-1:0]  opOffset,
  input  wire logic [4:0]            opRegSel,
  input  wire logic [IO_AW-1:0]      opIoAddr,
  input  wire logic [7:0]            regRdData,
  input  wire logic [7:0]            ioRdData,
  input  wire logic                  pcLoad,
  input  wire logic [PC_WIDTH-1:0]   pcLoadValue,
  output logic                       opDone,
  output logic [PC_WIDTH-1:0]        programCounter,
  output logic                       pcRedirect,
  output logic [7:0]                 statusRegister,
  output logic                       regWrEn,
  output logic [4:0]                 regWrSel,
  output logic [7:0]                 regWrData,
  output logic                       ioWrEn,
  output logic [IO_AW-1:0]           ioWrAddr,
  output logic [7:0]                 ioWrData
);
  typedef struct packed
  {
    fbbu_pkg::fbbu_state_t state;
    logic                  done;
    logic [PC_WIDTH-1:0]   pc;
    logic                  redirect;
    logic [7:0]            status;
    logic                  regWe;
    logic [4:0]            regSel;
    logic [7:0]            regData;
    logic                  ioWe;
    logic [IO_AW-1:0]      ioAddr;
    logic [7:0]            ioData;
    logic                  ioOp;
  } fbbu_state_s_t;

  fbbu_state_s_t cur_reg;
  fbbu_state_s_t cur_next;

  fbbu_pkg::fbbu_shift_t shiftKind;
  logic [7:0]            shiftResult;
  logic                  shC;
  logic                  shZ;
  logic                  shN;
  logic                  shV;
  logic                  shS;
  logic [PC_WIDTH-1:0]   branchTarget;
  logic                  condMet;

  function automatic fbbu_pkg::fbbu_shift_t shift_of(input fbbu_pkg::fbbu_op_t op);
    case (op)
      fbbu_pkg::OP_LOGICAL_RIGHT_SHIFT: shift_of = fbbu_pkg::SH_LSR;
      fbbu_pkg::OP_ROTATE_LEFT_CARRY:   shift_of = fbbu_pkg::SH_ROL;
      fbbu_pkg::OP_ROTATE_RIGHT_CARRY:  shift_of = fbbu_pkg::SH_ROR;
      fbbu_pkg::OP_ARITH_RIGHT_SHIFT:   shift_of = fbbu_pkg::SH_ASR;
      default:                          shift_of = fbbu_pkg::SH_LSL;
    endcase
  endfunction : shift_of

  function automatic logic is_shift(input fbbu_pkg::fbbu_op_t op);
    is_shift = (op == fbbu_pkg::OP_LOGICAL_LEFT_SHIFT) ||
               (op == fbbu_pkg::OP_LOGICAL_RIGHT_SHIFT) ||
               (op == fbbu_pkg::OP_ROTATE_LEFT_CARRY) ||
               (op == fbbu_pkg::OP_ROTATE_RIGHT_CARRY) ||
               (op == fbbu_pkg::OP_ARITH_RIGHT_SHIFT);
  endfunction : is_shift

  assign shiftKind = shift_of(opCode);

  fbbu_shifter u_shifter
  (
    .carryIn  (cur_reg.status[`FBBU_FLAG_C]),
    .operand  (regRdData),
    .kind     (shiftKind),
    .result   (shiftResult),
    .carryOut (shC),
    .zeroOut  (shZ),
    .negOut   (shN),
    .ovfOut   (shV),
    .signOut  (shS)
  );

  fbbu_branch_target #(.PC_WIDTH(PC_WIDTH), .OFS_WIDTH(OFS_WIDTH)) u_target
  (
    .pcNow  (cur_reg.pc),
    .offset (opOffset),
    .target (branchTarget)
  );

  // One flag selected by index serves every single-flag branch pair
  always_comb
  begin
    condMet = 1'b0;
    case (opCode)
      fbbu_pkg::OP_BRANCH_FLAG_SET:  condMet = cur_reg.status[opBitSel];
      fbbu_pkg::OP_BRANCH_FLAG_ZERO: condMet = ~cur_reg.status[opBitSel];
      fbbu_pkg::OP_BRANCH_SIGNED_GE:
        condMet = ~(cur_reg.status[`FBBU_FLAG_N] ^ cur_reg.status[`FBBU_FLAG_V]);
      fbbu_pkg::OP_BRANCH_SIGNED_LT:
        condMet = cur_reg.status[`FBBU_FLAG_N] ^ cur_reg.status[`FBBU_FLAG_V];
      default: condMet = 1'b0;
    endcase
  end

  always_comb
  begin
    cur_next          = cur_reg;
    cur_next.done     = 1'b0;
    cur_next.redirect = 1'b0;
    cur_next.regWe    = 1'b0;
    cur_next.ioWe     = 1'b0;
    if (pcLoad)
    begin
      cur_next.pc = pcLoadValue;
    end
    case (cur_reg.state)
      fbbu_pkg::ST_IDLE:
      begin
        if (opValid)
        begin
          case (opCode)
            fbbu_pkg::OP_BRANCH_FLAG_SET, fbbu_pkg::OP_BRANCH_FLAG_ZERO,
            fbbu_pkg::OP_BRANCH_SIGNED_GE, fbbu_pkg::OP_BRANCH_SIGNED_LT:
            begin
              // Flags are never touched by a branch
              if (condMet)
              begin
                cur_next.state = fbbu_pkg::ST_SECOND;
              end
              else
              begin
                cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                cur_next.done = 1'b1;
              end
            end
            fbbu_pkg::OP_IO_BIT_SET, fbbu_pkg::OP_IO_BIT_CLEAR:
            begin
              // Read-modify-write needs a second cycle to write back
              cur_next.ioAddr = opIoAddr;
              cur_next.ioData = ioRdData;
              cur_next.ioData[opBitSel] = (opCode == fbbu_pkg::OP_IO_BIT_SET);
              // Remembered so that the second cycle never mistakes the op for a branch
              cur_next.ioOp   = 1'b1;
              cur_next.state  = fbbu_pkg::ST_SECOND;
            end
            fbbu_pkg::OP_FLAG_SET_BY_INDEX:
            begin
              cur_next.status[opBitSel] = 1'b1;
              cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
              cur_next.done = 1'b1;
            end
            fbbu_pkg::OP_FLAG_CLEAR_BY_INDEX:
            begin
              cur_next.status[opBitSel] = 1'b0;
              cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
              cur_next.done = 1'b1;
            end
            fbbu_pkg::OP_BIT_TO_XFERBIT:
            begin
              cur_next.status[`FBBU_FLAG_T] = regRdData[opBitSel];
              cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
              cur_next.done = 1'b1;
            end
            fbbu_pkg::OP_XFERBIT_TO_BIT:
            begin
              cur_next.regWe   = 1'b1;
              cur_next.regSel  = opRegSel;
              cur_next.regData = regRdData;
              cur_next.regData[opBitSel] = cur_reg.status[`FBBU_FLAG_T];
              cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
              cur_next.done = 1'b1;
            end
            default:
            begin
              if (is_shift(opCode))
              begin
                cur_next.regWe   = 1'b1;
                cur_next.regSel  = opRegSel;
                cur_next.regData = shiftResult;
                cur_next.status[`FBBU_FLAG_C] = shC;
                cur_next.status[`FBBU_FLAG_Z] = shZ;
                cur_next.status[`FBBU_FLAG_N] = shN;
                cur_next.status[`FBBU_FLAG_V] = shV;
                cur_next.status[`FBBU_FLAG_S] = shS;
                cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                cur_next.done = 1'b1;
              end
            end
          endcase
        end
      end
      fbbu_pkg::ST_SECOND:
      begin
        cur_next.state = fbbu_pkg::ST_IDLE;
        cur_next.done  = 1'b1;
        cur_next.ioOp  = 1'b0;
        if (cur_reg.ioOp)
        begin
          cur_next.ioWe = 1'b1;
          cur_next.pc   = cur_reg.pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
        else
        begin
          cur_next.pc       = branchTarget;
          cur_next.redirect = 1'b1;
        end
      end
      default: cur_next.state = fbbu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cur_reg          <= '0;
      cur_reg.state    <= fbbu_pkg::ST_IDLE;
      cur_reg.pc       <= PC_WIDTH'(`FBBU_PC_RESET);
      cur_reg.status   <= `FBBU_STATUS_RESET;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign opDone         = cur_reg.done;
  assign programCounter = cur_reg.pc;
  assign pcRedirect     = cur_reg.redirect;
  assign statusRegister = cur_reg.status;
  assign regWrEn        = cur_reg.regWe;
  assign regWrSel       = cur_reg.regSel;
  assign regWrData      = cur_reg.regData;
  assign ioWrEn         = cur_reg.ioWe;
  assign ioWrAddr       = cur_reg.ioAddr;
  assign ioWrData       = cur_reg.ioData;

  property p_taken_two;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && condMet)
      |=> !opDone ##1 (opDone && pcRedirect);
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not 2 cycles");

  property p_fall_one;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && !pcLoad && !condMet &&
       (opCode == fbbu_pkg::OP_BRANCH_FLAG_SET || opCode == fbbu_pkg::OP_BRANCH_FLAG_ZERO))
      |=> opDone && !pcRedirect &&
          programCounter == PC_WIDTH'($past(programCounter) + {{(PC_WIDTH-1){1'b0}}, 1'b1});
  endproperty
  a_fall_one: assert property (p_fall_one) else $error("untaken branch wrong");

  property p_branch_keeps_flags;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid &&
       (opCode == fbbu_pkg::OP_BRANCH_FLAG_SET || opCode == fbbu_pkg::OP_BRANCH_FLAG_ZERO))
      |=> $stable(statusRegister);
  endproperty
  a_branch_keeps_flags: assert property (p_branch_keeps_flags) else $error("branch changed flags");

  property p_ge;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_BRANCH_SIGNED_GE &&
       (statusRegister[`FBBU_FLAG_N] == statusRegister[`FBBU_FLAG_V]))
      |=> ##1 pcRedirect;
  endproperty
  a_ge: assert property (p_ge) else $error("signed ge not taken");

  property p_lt;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_BRANCH_SIGNED_LT &&
       (statusRegister[`FBBU_FLAG_N] == statusRegister[`FBBU_FLAG_V]))
      |=> opDone && !pcRedirect;
  endproperty
  a_lt: assert property (p_lt) else $error("signed lt taken wrongly");

  property p_io_two;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_IO_BIT_SET)
      |=> !ioWrEn ##1 (ioWrEn && ioWrData[$past(opBitSel, 2)]);
  endproperty
  a_io_two: assert property (p_io_two) else $error("io bit set wrong");

  property p_lsl;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid &&
       opCode == fbbu_pkg::OP_LOGICAL_LEFT_SHIFT)
      |=> regWrEn && regWrData == {$past(regRdData[6:0]), 1'b0} &&
          statusRegister[`FBBU_FLAG_C] == $past(regRdData[7]);
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift wrong");

  property p_ror;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid &&
       opCode == fbbu_pkg::OP_ROTATE_RIGHT_CARRY)
      |=> regWrData == {$past(statusRegister[`FBBU_FLAG_C]), $past(regRdData[7:1])} &&
          statusRegister[`FBBU_FLAG_C] == $past(regRdData[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_bst;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_BIT_TO_XFERBIT)
      |=> statusRegister[`FBBU_FLAG_T] == $past(regRdData[opBitSel]) && opDone;
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");

  property p_io_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_IO_BIT_CLEAR)
      |=> !ioWrEn ##1 (ioWrEn && opDone && !ioWrData[$past(opBitSel, 2)]);
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");

  property p_lsr;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid &&
       opCode == fbbu_pkg::OP_LOGICAL_RIGHT_SHIFT)
      |=> regWrEn && regWrData == {1'b0, $past(regRdData[7:1])} &&
          statusRegister[`FBBU_FLAG_C] == $past(regRdData[0]);
  endproperty
  a_lsr: assert property (p_lsr) else $error("right shift wrong");

  property p_bld;
    @(posedge sys_clk) disable iff (!rst_b)
      (cur_reg.state == fbbu_pkg::ST_IDLE && opValid && opCode == fbbu_pkg::OP_XFERBIT_TO_BIT)
      |=> regWrEn && regWrData[$past(opBitSel)] == $past(statusRegister[`FBBU_FLAG_T]) &&
          $stable(statusRegister);
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong");

  c_taken: cover property (@(posedge sys_clk) disable iff (!rst_b) pcRedirect);
  c_io: cover property (@(posedge sys_clk) disable iff (!rst_b) ioWrEn);
  c_shift: cover property (@(posedge sys_clk) disable iff (!rst_b) regWrEn);
  c_fall: cover property (@(posedge sys_clk) disable iff (!rst_b)
    opDone && !pcRedirect && !regWrEn && !ioWrEn);
endmodule : fbbu_exec_unit
`default_nettype wire

// file: verification/tb_flag_branch_bit_ops_unit.sv
// Self-checking bench for the flag, branch and bit-operation execution unit.
// Assumes fbbu_pkg is compiled first; the bench drives every port of the unit itself.
`default_nettype none
module tb_flag_branch_bit_ops_unit;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TIMEOUT = 20000;
  logic               sys_clk;
  logic               rst_b;
  logic               opValid;
  fbbu_pkg::fbbu_op_t opCode;
  logic [2:0]         opBitSel;
  logic [6:0]         opOffset;
  logic [4:0]         opRegSel, opIoAddr;
  logic [7:0]         regRdData, ioRdData, statusRegister, regWrData, ioWrData;
  logic               pcLoad, opDone, pcRedirect, regWrEn, ioWrEn;
  logic [15:0]        pcLoadValue, programCounter;
  logic [4:0]         regWrSel, ioWrAddr;
  logic [7:0]         mSreg;
  logic [15:0]        mPc;
  int                 failures, totalChecks, cycles;

  fbbu_exec_unit #(.PC_WIDTH(16), .OFS_WIDTH(7), .IO_AW(5)) dut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .opValid(opValid), .opCode(opCode),
    .opBitSel(opBitSel), .opOffset(opOffset), .opRegSel(opRegSel), .opIoAddr(opIoAddr),
    .regRdData(regRdData), .ioRdData(ioRdData), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .opDone(opDone), .programCounter(programCounter), .pcRedirect(pcRedirect),
    .statusRegister(statusRegister), .regWrEn(regWrEn), .regWrSel(regWrSel),
    .regWrData(regWrData), .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr), .ioWrData(ioWrData)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles >= TIMEOUT)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic doReset();
    rst_b = 1'b0;
    repeat (3) tick();
    check(programCounter, 16'h0000);
    check(statusRegister, 8'h00);
    check({opDone, pcRedirect, regWrEn, ioWrEn}, 4'h0);
    rst_b = 1'b1;
    mPc = 16'h0000;
    mSreg = 8'h00;
  endtask : doReset

  // Leaves opValid high so that the next call runs back to back
  task automatic runOp(input fbbu_pkg::fbbu_op_t op, input logic [2:0] bs);
    int n;
    logic taken, c, expReg, expIo;
    logic [7:0] r, exS, expIoData;
    logic [15:0] exPc;
    opValid = 1'b1;
    opCode = op;
    opBitSel = bs;
    opOffset = 7'($urandom);
    opRegSel = 5'($urandom);
    opIoAddr = 5'($urandom);
    regRdData = 8'($urandom);
    ioRdData = 8'($urandom);
    r = regRdData;
    exS = mSreg;
    taken = 1'b0;
    c = 1'b0;
    expReg = 1'b0;
    expIo = 1'b0;
    expIoData = 8'h00;
    case (op)
      fbbu_pkg::OP_BRANCH_FLAG_SET: taken = mSreg[bs];
      fbbu_pkg::OP_BRANCH_FLAG_ZERO: taken = !mSreg[bs];
      fbbu_pkg::OP_BRANCH_SIGNED_GE: taken = !(mSreg[2] ^ mSreg[3]);
      fbbu_pkg::OP_BRANCH_SIGNED_LT: taken = mSreg[2] ^ mSreg[3];
      fbbu_pkg::OP_IO_BIT_SET: expIoData = ioRdData | (8'h01 << bs);
      fbbu_pkg::OP_IO_BIT_CLEAR: expIoData = ioRdData & ~(8'h01 << bs);
      fbbu_pkg::OP_LOGICAL_LEFT_SHIFT: {c, r} = {r, 1'b0};
      fbbu_pkg::OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, r};
      fbbu_pkg::OP_ROTATE_LEFT_CARRY: {c, r} = {r, mSreg[0]};
      fbbu_pkg::OP_ROTATE_RIGHT_CARRY: {r, c} = {mSreg[0], r};
      fbbu_pkg::OP_ARITH_RIGHT_SHIFT: {r, c} = {r[7], r};
      fbbu_pkg::OP_FLAG_SET_BY_INDEX: exS[bs] = 1'b1;
      fbbu_pkg::OP_FLAG_CLEAR_BY_INDEX: exS[bs] = 1'b0;
      fbbu_pkg::OP_BIT_TO_XFERBIT: exS[6] = r[bs];
      fbbu_pkg::OP_XFERBIT_TO_BIT: r[bs] = mSreg[6];
      default: ;
    endcase
    expIo = op inside {fbbu_pkg::OP_IO_BIT_SET, fbbu_pkg::OP_IO_BIT_CLEAR};
    expReg = op inside {[fbbu_pkg::OP_LOGICAL_LEFT_SHIFT:fbbu_pkg::OP_ARITH_RIGHT_SHIFT]};
    if (expReg)
    begin
      // After a shift V is N xor C and S is N xor V
      exS[0] = c;
      exS[1] = (r == 8'h00);
      exS[2] = r[7];
      exS[3] = r[7] ^ c;
      exS[4] = exS[2] ^ exS[3];
    end
    expReg = expReg || (op == fbbu_pkg::OP_XFERBIT_TO_BIT);
    exPc = mPc + 16'h0001 + (taken ? {{9{opOffset[6]}}, opOffset} : 16'h0000);
    tick();
    n = 1;
    while (opDone !== 1'b1 && n < 4)
    begin
      tick();
      n++;
    end
    check(16'(n), (taken || expIo) ? 16'h0002 : 16'h0001);
    check(pcRedirect, taken);
    check(programCounter, exPc);
    check(statusRegister, exS);
    check(regWrEn, expReg);
    if (expReg)
      check({regWrSel, regWrData}, {opRegSel, r});
    check(ioWrEn, expIo);
    if (expIo)
      check({ioWrAddr, ioWrData}, {opIoAddr, expIoData});
    mSreg = exS;
    mPc = exPc;
  endtask : runOp

  task automatic idle();
    opValid = 1'b0;
    tick();
    check({opDone, pcRedirect, regWrEn, ioWrEn}, 4'h0);
  endtask : idle

  initial
  begin
    rst_b = 1'b0;
    opValid = 1'b0;
    opCode = fbbu_pkg::OP_NONE;
    opBitSel = 3'h0;
    opOffset = 7'h00;
    opRegSel = 5'h00;
    opIoAddr = 5'h00;
    regRdData = 8'h00;
    ioRdData = 8'h00;
    pcLoad = 1'b0;
    pcLoadValue = 16'h0000;
    failures = 0;
    totalChecks = 0;
    cycles = 0;
    void'($urandom(32'h40DE));
    doReset();
    // Every flag index set, branched on, cleared and branched on again
    for (int i = 0; i < 8; i++)
    begin
      runOp(fbbu_pkg::OP_FLAG_SET_BY_INDEX, 3'(i));
      runOp(fbbu_pkg::OP_BRANCH_FLAG_SET, 3'(i));
      runOp(fbbu_pkg::OP_BRANCH_FLAG_ZERO, 3'(i));
      runOp(fbbu_pkg::OP_FLAG_CLEAR_BY_INDEX, 3'(i));
      runOp(fbbu_pkg::OP_BRANCH_FLAG_ZERO, 3'(i));
      runOp(fbbu_pkg::OP_BRANCH_FLAG_SET, 3'(i));
    end
    idle();
    // Load near the top so that branches also wrap the address
    pcLoad = 1'b1;
    pcLoadValue = 16'hFFF0;
    tick();
    pcLoad = 1'b0;
    check(programCounter, 16'hFFF0);
    mPc = 16'hFFF0;
    repeat (400)
    begin
      runOp(fbbu_pkg::fbbu_op_t'(5'($urandom_range(15, 1))), 3'($urandom));
      if ($urandom_range(3, 0) == 0)
        idle();
    end
    // An unknown operation must be ignored
    opValid = 1'b1;
    opCode = fbbu_pkg::fbbu_op_t'(5'h1F);
    repeat (3)
    begin
      tick();
      check({opDone, regWrEn, ioWrEn}, 3'h0);
    end
    check(programCounter, mPc);
    check(statusRegister, mSreg);
    idle();
    doReset();
    repeat (20) runOp(fbbu_pkg::fbbu_op_t'(5'($urandom_range(15, 1))), 3'($urandom));
    idle();
    end_of_test();
  end
endmodule : tb_flag_branch_bit_ops_unit
`default_nettype wire
